// ==== rtl/pcr_regs.sv ====
`timescale 1ns/100ps
// Function
// - writing 1 to pending bit requests message
// - send one at a time, lowest, unmasked
// - pending reads outstanding state, link read-only
// - reserved bits read as zero
// - message number field, resets zero
// - port type only endpoint or root values
// - mode pin loads port type at start
// - capability version fixed read-only one
// - header resets next 00, id 10
// - slot power scale two-bit encoding kept
// - endpoint captures slot power limit message
// - role-based error bit always reads one
// - deep idle exit tolerance three bits
// - light idle exit tolerance three bits
// - extended tag supported fixed zero
// - phantom function supported fixed zero
// - max payload supported, reset per channel
// - mask bit one suppresses that vector
// - multiple message enable gives vector count
module pcr_regs #(
    parameter int CHANNEL = 0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic root_mode_pin_i,
    input wire logic sh_wr_i,
    input wire logic sh_rd_i,
    input wire logic [1:0] sh_sel_i,
    input wire logic [31:0] sh_wdata_i,
    output logic [31:0] sh_rdata_o,
    output logic sh_rvalid_o,
    input wire logic cfg_rd_i,
    input wire logic [1:0] cfg_sel_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic [31:0] vector_mask_bits_i,
    input wire logic msi_enable_i,
    input wire logic [2:0] msg_enable_count_i,
    input wire logic slot_power_msg_i,
    input wire logic [1:0] slot_power_scale_i,
    input wire logic [7:0] slot_power_value_i,
    output logic msi_req_o,
    output logic [4:0] msi_vector_o,
    input wire logic msi_ack_i,
    output logic [4:0] int_msg_number_o
);
    // vector count allocated by the multiple message enable code
    function automatic logic [31:0] allowed_mask(input logic [2:0] mme);
        logic [31:0] m;
        m = 32'hFFFF_FFFF;
        if (mme <= pcr_pkg::MME_MAX) begin
            m = ~(32'hFFFF_FFFE << ((6'h01 << mme) - 6'h01));
        end
        return m;
    endfunction : allowed_mask

    // register state
    logic [31:0] pending_q;
    logic [31:0] pending_d;
    logic [4:0] msg_num_q;
    logic slot_q;
    logic [3:0] type_q;
    logic [3:0] type_d;
    logic [7:0] next_q;
    logic [7:0] id_q;
    logic [1:0] scale_q;
    logic [1:0] scale_d;
    logic [7:0] limit_q;
    logic [7:0] limit_d;
    logic [2:0] l1_lat_q;
    logic [2:0] l0s_lat_q;
    logic [2:0] payload_q;
    logic [31:0] sh_rdata_q;
    logic sh_rvalid_q;
    logic [31:0] cfg_rdata_q;
    logic cfg_rvalid_q;
    logic mode_meta_q;
    logic mode_sync_q;
    logic [1:0] mode_step_q;

    logic seq_clr;
    logic [4:0] seq_clr_vec;

    // the sync pair settles on edges 1 and 2, so the type loads on edge 3
    localparam logic [1:0] MODE_LOAD_STEP = 2'h2;

    // channel zero supports a larger payload than the others
    localparam logic [2:0] PAYLOAD_RST = (CHANNEL == 0) ?
        pcr_pkg::PAYLOAD_RST_CH0 : pcr_pkg::PAYLOAD_RST_CHN;

    // write decode
    wire logic wr_pend = sh_wr_i && (sh_sel_i == pcr_pkg::SEL_PENDING);
    wire logic wr_hdr = sh_wr_i && (sh_sel_i == pcr_pkg::SEL_CAP_HDR);
    wire logic wr_dev = sh_wr_i && (sh_sel_i == pcr_pkg::SEL_DEV_CAP);
    wire logic is_root = (type_q == pcr_pkg::TYPE_ROOT);
    wire logic [3:0] wr_type = sh_wdata_i[pcr_pkg::TYPE_LSB +: 4];
    wire logic type_legal = (wr_type == pcr_pkg::TYPE_ENDPOINT) ||
        (wr_type == pcr_pkg::TYPE_ROOT);
    wire logic [31:0] clr_mask = seq_clr ? (32'h1 << seq_clr_vec) :
        32'h0;
    wire logic [31:0] allowed = msi_enable_i ?
        allowed_mask(msg_enable_count_i) : 32'h0;

    // a software 1 written in the clearing cycle survives the clear
    assign pending_d = wr_pend ? sh_wdata_i :
        (pending_q & ~clr_mask);

    // prohibited port types are ignored; the mode pin wins once
    assign type_d = (mode_step_q == MODE_LOAD_STEP) ?
        (mode_sync_q ? pcr_pkg::TYPE_ROOT : pcr_pkg::TYPE_ENDPOINT) :
        ((wr_hdr && type_legal) ? wr_type : type_q);

    // message capture beats a software write in the same cycle
    assign scale_d = (slot_power_msg_i && !is_root) ? slot_power_scale_i :
        (wr_dev ? sh_wdata_i[pcr_pkg::SCALE_LSB +: 2] : scale_q);
    assign limit_d = (slot_power_msg_i && !is_root) ? slot_power_value_i :
        (wr_dev ? sh_wdata_i[pcr_pkg::LIMIT_LSB +: 8] : limit_q);

    // read images; reserved and fixed bits come from constants
    wire logic [31:0] hdr_img = {2'b00, msg_num_q, slot_q, type_q,
        pcr_pkg::CAP_VERSION, next_q, id_q};
    wire logic [31:0] dev_img = {4'h0, scale_q, limit_q, 2'b00, 1'b1,
        3'b000, l1_lat_q, l0s_lat_q, 1'b0, 2'b00, payload_q};
    wire logic [31:0] sh_img = (sh_sel_i == pcr_pkg::SEL_PENDING) ?
        pending_q : (sh_sel_i == pcr_pkg::SEL_CAP_HDR) ? hdr_img :
        (sh_sel_i == pcr_pkg::SEL_DEV_CAP) ? dev_img : 32'h0;
    wire logic [31:0] cfg_img = (cfg_sel_i == pcr_pkg::SEL_PENDING) ?
        pending_q : (cfg_sel_i == pcr_pkg::SEL_CAP_HDR) ? hdr_img :
        (cfg_sel_i == pcr_pkg::SEL_DEV_CAP) ? dev_img : 32'h0;

    // mode pin is asynchronous: two flops, then one capture after release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
            mode_step_q <= 2'h0;
        end else begin
            mode_meta_q <= root_mode_pin_i;
            mode_sync_q <= mode_meta_q;
            if (mode_step_q != 2'h3) begin
                mode_step_q <= mode_step_q + 2'h1;
            end
        end
    end

    // pending word and the link-visible port type
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= pcr_pkg::PENDING_RST;
            type_q <= pcr_pkg::TYPE_ENDPOINT;
        end else begin
            pending_q <= pending_d;
            type_q <= type_d;
        end
    end

    // capability header fields, writable from the internal bus only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msg_num_q <= pcr_pkg::MSG_NUM_RST;
            slot_q <= 1'b0;
            next_q <= pcr_pkg::NEXT_PTR_RST;
            id_q <= pcr_pkg::CAP_ID_RST;
        end else if (wr_hdr) begin
            msg_num_q <= sh_wdata_i[pcr_pkg::MSG_NUM_LSB +: 5];
            slot_q <= sh_wdata_i[pcr_pkg::SLOT_BIT];
            next_q <= sh_wdata_i[pcr_pkg::NEXT_LSB +: 8];
            id_q <= sh_wdata_i[pcr_pkg::ID_LSB +: 8];
        end
    end

    // device capability fields
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scale_q <= 2'b00;
            limit_q <= 8'h00;
            l1_lat_q <= pcr_pkg::LATENCY_RST;
            l0s_lat_q <= pcr_pkg::LATENCY_RST;
            payload_q <= PAYLOAD_RST;
        end else begin
            scale_q <= scale_d;
            limit_q <= limit_d;
            if (wr_dev) begin
                l1_lat_q <= sh_wdata_i[pcr_pkg::L1_LAT_LSB +: 3];
                l0s_lat_q <= sh_wdata_i[pcr_pkg::L0S_LAT_LSB +: 3];
                payload_q <= sh_wdata_i[pcr_pkg::PAYLOAD_LSB +: 3];
            end
        end
    end

    // registered read answers; link side has no write path at all
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_rdata_q <= 32'h0;
            sh_rvalid_q <= 1'b0;
            cfg_rdata_q <= 32'h0;
            cfg_rvalid_q <= 1'b0;
        end else begin
            sh_rvalid_q <= sh_rd_i;
            cfg_rvalid_q <= cfg_rd_i;
            if (sh_rd_i) begin
                sh_rdata_q <= sh_img;
            end
            if (cfg_rd_i) begin
                cfg_rdata_q <= cfg_img;
            end
        end
    end

    pcr_msi_seq u_seq (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pending_i(pending_q),
        .vector_mask_bits_i(vector_mask_bits_i),
        .allowed_i(allowed),
        .msi_ack_i(msi_ack_i),
        .msi_req_o(msi_req_o),
        .msi_vector_o(msi_vector_o),
        .clr_valid_o(seq_clr),
        .clr_vector_o(seq_clr_vec)
    );

    assign sh_rdata_o = sh_rdata_q;
    assign sh_rvalid_o = sh_rvalid_q;
    assign cfg_rdata_o = cfg_rdata_q;
    assign cfg_rvalid_o = cfg_rvalid_q;
    assign int_msg_number_o = msg_num_q;
endmodule : pcr_regs

// ==== rtl/pcr_pkg.sv ====
package pcr_pkg;
    // register select codes on both access sides
    localparam logic [1:0] SEL_PENDING = 2'h0;
    localparam logic [1:0] SEL_CAP_HDR = 2'h1;
    localparam logic [1:0] SEL_DEV_CAP = 2'h2;

    // reset values
    localparam logic [31:0] PENDING_RST = 32'h0000_0000;
    localparam logic [4:0] MSG_NUM_RST = 5'h00;
    localparam logic [3:0] TYPE_ENDPOINT = 4'h0;
    localparam logic [3:0] TYPE_ROOT = 4'h4;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [7:0] NEXT_PTR_RST = 8'h00;
    localparam logic [7:0] CAP_ID_RST = 8'h10;
    localparam logic [2:0] PAYLOAD_RST_CH0 = 3'h2;
    localparam logic [2:0] PAYLOAD_RST_CHN = 3'h1;
    localparam logic [2:0] LATENCY_RST = 3'h0;

    // capability header field positions
    localparam int MSG_NUM_LSB = 25;
    localparam int SLOT_BIT = 24;
    localparam int TYPE_LSB = 20;
    localparam int VER_LSB = 16;
    localparam int NEXT_LSB = 8;
    localparam int ID_LSB = 0;

    // device capability field positions
    localparam int SCALE_LSB = 26;
    localparam int LIMIT_LSB = 18;
    localparam int ROLE_ERR_BIT = 15;
    localparam int L1_LAT_LSB = 9;
    localparam int L0S_LAT_LSB = 6;
    localparam int EXT_TAG_BIT = 5;
    localparam int PHANTOM_LSB = 3;
    localparam int PAYLOAD_LSB = 0;

    // multiple message enable: 000..101 give 1..32 vectors
    localparam logic [2:0] MME_MAX = 3'h5;
endpackage : pcr_pkg

// ==== rtl/pcr_msi_seq.sv ====
`timescale 1ns/100ps
module pcr_msi_seq (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] pending_i,
    input wire logic [31:0] vector_mask_bits_i,
    input wire logic [31:0] allowed_i,
    input wire logic msi_ack_i,
    output logic msi_req_o,
    output logic [4:0] msi_vector_o,
    output logic clr_valid_o,
    output logic [4:0] clr_vector_o
);
    typedef enum logic [1:0] {SQ_IDLE, SQ_SEND, SQ_SETTLE} pcr_seq_e;

    // lowest set bit wins
    function automatic logic [4:0] lowest_bit(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : lowest_bit

    pcr_seq_e state_q;
    pcr_seq_e state_d;
    logic [4:0] vec_q;
    logic [4:0] vec_d;
    logic req_q;
    logic req_d;
    logic clr_q;
    logic clr_d;

    // masked-off vectors are skipped, not dropped
    wire logic [31:0] eligible = pending_i & ~vector_mask_bits_i & allowed_i;
    wire logic [4:0] pick = lowest_bit(eligible);

    // one message at a time; settle lets the pending clear land first
    always_comb begin
        state_d = state_q;
        vec_d = vec_q;
        req_d = req_q;
        clr_d = 1'b0;
        case (state_q)
            SQ_IDLE: begin
                if (|eligible) begin
                    state_d = SQ_SEND;
                    vec_d = pick;
                    req_d = 1'b1;
                end
            end
            SQ_SEND: begin
                if (msi_ack_i) begin
                    state_d = SQ_SETTLE;
                    req_d = 1'b0;
                    clr_d = 1'b1;
                end
            end
            SQ_SETTLE: state_d = SQ_IDLE;
            default: begin
                state_d = SQ_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SQ_IDLE;
            vec_q <= 5'h00;
            req_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            vec_q <= vec_d;
            req_q <= req_d;
            clr_q <= clr_d;
        end
    end

    assign msi_req_o = req_q;
    assign msi_vector_o = vec_q;
    assign clr_valid_o = clr_q;
    assign clr_vector_o = vec_q;
endmodule : pcr_msi_seq

// ==== bench/pcr_regs_props.sv ====
`timescale 1ns/100ps
// watches the register bank pins only
module pcr_regs_props #(
    parameter int CHANNEL = 0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic root_mode_pin_i,
    input wire logic sh_wr_i,
    input wire logic sh_rd_i,
    input wire logic [1:0] sh_sel_i,
    input wire logic [31:0] sh_wdata_i,
    input wire logic [31:0] sh_rdata_o,
    input wire logic sh_rvalid_o,
    input wire logic cfg_rd_i,
    input wire logic [1:0] cfg_sel_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic [31:0] vector_mask_bits_i,
    input wire logic msi_enable_i,
    input wire logic [2:0] msg_enable_count_i,
    input wire logic slot_power_msg_i,
    input wire logic [1:0] slot_power_scale_i,
    input wire logic [7:0] slot_power_value_i,
    input wire logic msi_req_o,
    input wire logic [4:0] msi_vector_o,
    input wire logic msi_ack_i,
    input wire logic [4:0] int_msg_number_o
);
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // both read sides answer exactly one cycle after the strobe
    sh_read_valid_a: assert property (sh_rd_i |=> sh_rvalid_o)
        else $error("internal read gave no valid");
    cfg_read_valid_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("link read gave no valid");
    // a request is held steady until the transmit side takes it
    req_hold_a: assert property (msi_req_o && !msi_ack_i |=>
        msi_req_o && $stable(msi_vector_o))
        else $error("request dropped or vector moved before ack");
    // one message per request: the taken request is gone for two cycles
    ack_drop_a: assert property (msi_req_o && msi_ack_i |=>
        !msi_req_o [*2])
        else $error("request not withdrawn after ack");
    // a masked vector is never started
    mask_block_a: assert property ($rose(msi_req_o) |->
        (($past(vector_mask_bits_i) >> msi_vector_o) & 32'h1) == 32'h0)
        else $error("masked vector requested");
    // vector stays inside the enabled count
    count_range_a: assert property ($rose(msi_req_o) &&
        $past(msg_enable_count_i) <= 3'h5 |->
        (msi_vector_o >> $past(msg_enable_count_i)) == 5'h00)
        else $error("vector outside enabled count");
    // fixed and reserved header and device capability bits seen from the link
    dev_fixed_a: assert property (cfg_rd_i && cfg_sel_i == 2'h2 |=>
        (cfg_rdata_o & 32'hF003_F038) == 32'h0000_8000)
        else $error("device capability fixed bits wrong");
    hdr_fixed_a: assert property (cfg_rd_i && cfg_sel_i == 2'h1 |=>
        (cfg_rdata_o & 32'hC00F_0000) == 32'h0001_0000)
        else $error("header version or reserved bits wrong");
endmodule : pcr_regs_props

bind pcr_regs pcr_regs_props #(.CHANNEL(CHANNEL)) u_props (.*);

// ==== bench/pcr_ack_model.sv ====
`timescale 1ns/100ps
// transmit side: takes each request after a programmable wait
module pcr_ack_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic msi_req_i,
    input wire logic [4:0] msi_vector_i,
    input wire logic [3:0] ack_delay_i,
    output logic msi_ack_o
);
    logic [3:0] wait_q;
    logic [4:0] sent_q[$];

    // one-cycle ack; never acks the same request twice
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msi_ack_o <= 1'b0;
            wait_q <= 4'h0;
        end else if (msi_req_i && !msi_ack_o && wait_q == ack_delay_i) begin
            msi_ack_o <= 1'b1;
            wait_q <= 4'h0;
            sent_q.push_back(msi_vector_i);
        end else begin
            msi_ack_o <= 1'b0;
            wait_q <= (msi_req_i && !msi_ack_o) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : pcr_ack_model

// ==== bench/test_pcr_regs.sv ====
`timescale 1ns/100ps
module test_pcr_regs;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic root_mode_pin_i = 1'b0;
    logic sh_wr_i = 1'b0;
    logic sh_rd_i = 1'b0;
    logic cfg_rd_i = 1'b0;
    logic [1:0] sh_sel_i = 2'h0;
    logic [1:0] cfg_sel_i = 2'h0;
    logic [31:0] sh_wdata_i = 32'h0;
    logic [31:0] vector_mask_bits_i = 32'h0;
    logic msi_enable_i = 1'b0;
    logic [2:0] msg_enable_count_i = 3'h0;
    logic slot_power_msg_i = 1'b0;
    logic [1:0] slot_power_scale_i = 2'h0;
    logic [7:0] slot_power_value_i = 8'h0;
    logic [3:0] ack_delay = 4'h0;
    logic [31:0] sh_rdata_o, cfg_rdata_o;
    logic sh_rvalid_o, cfg_rvalid_o, msi_req_o, msi_ack_i;
    logic [4:0] msi_vector_o, int_msg_number_o;
    int miscompares = 0;
    int num_checks = 0;

    pcr_regs #(.CHANNEL(0)) DUT (.*);
    pcr_ack_model u_ack (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .msi_req_i(msi_req_o), .msi_vector_i(msi_vector_o),
        .ack_delay_i(ack_delay), .msi_ack_o(msi_ack_i));

    initial forever #25 ref_clk_i = ~ref_clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        @(posedge ref_clk_i);
        sh_wr_i <= 1'b1;
        sh_sel_i <= sel;
        sh_wdata_i <= d;
        @(posedge ref_clk_i);
        sh_wr_i <= 1'b0;
    endtask : wr

    // link side when lnk is set; answer looked at while valid stands
    task automatic rd(input logic lnk, input logic [1:0] sel,
        input logic [31:0] exp);
        @(posedge ref_clk_i);
        sh_rd_i <= !lnk;
        cfg_rd_i <= lnk;
        sh_sel_i <= sel;
        cfg_sel_i <= sel;
        @(posedge ref_clk_i);
        sh_rd_i <= 1'b0;
        cfg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        check({31'h0, lnk ? cfg_rvalid_o : sh_rvalid_o}, 32'h1);
        check(lnk ? cfg_rdata_o : sh_rdata_o, exp);
    endtask : rd

    task automatic slot_msg(input logic [1:0] s, input logic [7:0] v);
        @(posedge ref_clk_i);
        slot_power_msg_i <= 1'b1;
        slot_power_scale_i <= s;
        slot_power_value_i <= v;
        @(posedge ref_clk_i);
        slot_power_msg_i <= 1'b0;
    endtask : slot_msg

    // bounded wait; extra edges let the pending bit clear behind the ack
    task automatic wait_sent(input int n);
        for (int i = 0; i < 200 && u_ack.sent_q.size() < n; i++)
            @(posedge ref_clk_i);
        repeat (3) @(posedge ref_clk_i);
        check(32'(u_ack.sent_q.size()), 32'(n));
    endtask : wait_sent

    // the port type is only valid a few edges after release
    task automatic do_reset(input logic pin);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        root_mode_pin_i <= pin;
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask : do_reset

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    initial begin
        #(3000 * 50);
        miscompares++;
        wrap_up();
    end

    initial begin
        do_reset(1'b0);
        rd(1'b0, pcr_pkg::SEL_PENDING, 32'h0000_0000);
        rd(1'b1, pcr_pkg::SEL_CAP_HDR, 32'h0001_0010);
        rd(1'b0, pcr_pkg::SEL_DEV_CAP, 32'h0000_8002);
        wr(pcr_pkg::SEL_DEV_CAP, 32'hFFFF_FFFF);
        rd(1'b0, pcr_pkg::SEL_DEV_CAP, 32'h0FFC_8FC7);
        rd(1'b1, pcr_pkg::SEL_DEV_CAP, 32'h0FFC_8FC7);
        slot_msg(2'h1, 8'h5A);
        rd(1'b0, pcr_pkg::SEL_DEV_CAP, 32'h0568_8FC7);
        wr(pcr_pkg::SEL_CAP_HDR, 32'hFFFF_FFFF);
        rd(1'b0, pcr_pkg::SEL_CAP_HDR, 32'h3F01_FFFF);
        check({27'h0, int_msg_number_o}, 32'h0000_001F);
        wr(pcr_pkg::SEL_CAP_HDR, 32'h0140_0010);
        rd(1'b1, pcr_pkg::SEL_CAP_HDR, 32'h0141_0010);
        slot_msg(2'h3, 8'hFF);
        rd(1'b0, pcr_pkg::SEL_DEV_CAP, 32'h0568_8FC7);
        wr(2'h3, 32'hFFFF_FFFF);
        rd(1'b0, 2'h3, 32'h0000_0000);
        // vector 1 masked, prompt ack
        @(posedge ref_clk_i);
        vector_mask_bits_i <= 32'h0000_0002;
        msi_enable_i <= 1'b1;
        msg_enable_count_i <= 3'h5;
        wr(pcr_pkg::SEL_PENDING, 32'h0000_0007);
        wait_sent(2);
        check({27'h0, u_ack.sent_q[0]}, 32'h0);
        check({27'h0, u_ack.sent_q[1]}, 32'h2);
        rd(1'b0, pcr_pkg::SEL_PENDING, 32'h0000_0002);
        // unmask with a slow ack
        @(posedge ref_clk_i);
        ack_delay <= 4'h6;
        vector_mask_bits_i <= 32'h0000_0000;
        wait_sent(3);
        check({27'h0, u_ack.sent_q[2]}, 32'h1);
        rd(1'b1, pcr_pkg::SEL_PENDING, 32'h0000_0000);
        // a single enabled vector keeps vector 1 waiting
        @(posedge ref_clk_i);
        msg_enable_count_i <= 3'h0;
        wr(pcr_pkg::SEL_PENDING, 32'h0000_0002);
        repeat (20) @(posedge ref_clk_i);
        rd(1'b0, pcr_pkg::SEL_PENDING, 32'h0000_0002);
        @(posedge ref_clk_i);
        msg_enable_count_i <= 3'h1;
        msi_enable_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        check(32'(u_ack.sent_q.size()), 32'h3);
        msi_enable_i <= 1'b1;
        wait_sent(4);
        check({27'h0, u_ack.sent_q[3]}, 32'h1);
        // a held request is cancelled by writing 0 over it
        msi_enable_i <= 1'b0;
        wr(pcr_pkg::SEL_PENDING, 32'h0000_0010);
        rd(1'b1, pcr_pkg::SEL_PENDING, 32'h0000_0010);
        wr(pcr_pkg::SEL_PENDING, 32'h0000_0000);
        rd(1'b0, pcr_pkg::SEL_PENDING, 32'h0000_0000);
        do_reset(1'b1);
        rd(1'b1, pcr_pkg::SEL_CAP_HDR, 32'h0041_0010);
        wrap_up();
    end
endmodule : test_pcr_regs
